// ===== core/sfp_sequencer.sv
// Program, erase and suspend sequencer of a serial NOR flash, APB status.
//
// How it works
// RULE1: quad program needs four-lane allow and arm
// RULE2: one program takes at most 256 bytes
// RULE3: quad program otherwise equals single-lane program
// RULE4: sector erase 20h needs write-arm latch
// RULE5: block D8h, half block 52h need arm
// RULE6: chip erase C7h/60h, no address, needs arm
// RULE7: select release off byte boundary discards command
// RULE8: busy high through self-timed cycle, status readable
// RULE9: finished cycle clears write-arm latch and busy
// RULE10: refuse protected targets; chip erase if any
// RULE11: suspend only when running, not yet suspended
// RULE12: suspend ignored during chip erase
// RULE13: erase suspended blocks erases and register writes; code blocks erases only, APB ctrl writes still land
// RULE14: program suspended blocks programs and erases
// RULE15: suspended erase still allows other-sector programs
// RULE16: commands on the suspended region are ignored
// RULE17: suspend sets flag at once, busy drops later
// RULE18: host waits before suspending after resume
// RULE19: power loss clears the suspended flag
// RULE20: resume only when suspended and idle
// RULE21: resume clears flag, busy within 200 ns
// RULE22: opcode 06h sets write-arm latch
// RULE23: bits sampled on serial clock rising edge
// RULE24: refused commands change no status bit
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps

module sfp_sequencer
  import sfp_pkg::*;
#(
  parameter int PROGRAM_CYCLES     = PROGRAM_CYC,
  parameter int SMALL_ERASE_CYCLES = SMALL_ERASE_CYC,
  parameter int HALF_ERASE_CYCLES  = HALF_ERASE_CYC,
  parameter int LARGE_ERASE_CYCLES = LARGE_ERASE_CYC,
  parameter int WHOLE_ERASE_CYCLES = WHOLE_ERASE_CYC
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial flash pins, driven by the host.
  input  wire logic        select_n,
  input  wire logic        serial_clock,
  input  wire logic        lane_zero,
  input  wire logic        lane_one,
  input  wire logic        lane_two,
  input  wire logic        lane_three,
  // Status.
  output logic             busy,
  output logic             write_arm_latch,
  output logic             suspended_flag
);

  localparam int susp_bound   = SUSPEND_LATENCY_CYC + 1;
  localparam int resume_bound = RESUME_BUSY_CYC;

  function automatic sfp_kind_type kind_of(input logic [7:0] op);
    case (op)
      OP_PAGE_PROG, OP_QUAD_PROG:       kind_of = KIND_PROGRAM;
      OP_SECTOR_ERASE:                  kind_of = KIND_SECTOR;
      OP_HALF_ERASE:                    kind_of = KIND_HALF;
      OP_BLOCK_ERASE:                   kind_of = KIND_BLOCK;
      OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: kind_of = KIND_CHIP;
      default:                          kind_of = KIND_NONE;
    endcase
  endfunction

  function automatic logic [23:0] region_mask(input sfp_kind_type k);
    case (k)
      KIND_PROGRAM: region_mask = PAGE_MASK;
      KIND_SECTOR:  region_mask = SECTOR_MASK;
      KIND_HALF:    region_mask = HALF_MASK;
      KIND_BLOCK:   region_mask = BLOCK_MASK;
      default:      region_mask = 24'h000000;
    endcase
  endfunction

  function automatic logic [31:0] duration(input sfp_kind_type k);
    case (k)
      KIND_PROGRAM: duration = 32'(PROGRAM_CYCLES);
      KIND_SECTOR:  duration = 32'(SMALL_ERASE_CYCLES);
      KIND_HALF:    duration = 32'(HALF_ERASE_CYCLES);
      KIND_BLOCK:   duration = 32'(LARGE_ERASE_CYCLES);
      default:      duration = 32'(WHOLE_ERASE_CYCLES);
    endcase
  endfunction

  // A protected span is a power-of-two run of units at one end of the
  // array, so checking the nearer end of an aligned target is enough.
  function automatic logic prot_hit(input sfp_ctrl_type c,
                                    input logic [23:0] lo,
                                    input logic [23:0] hi);
    logic [24:0] unit;
    logic [24:0] span;
    unit = c.protect_granule_select ? PROT_SMALL_UNIT : PROT_LARGE_UNIT;
    span = unit << (c.protect_span - 3'h1);
    if (c.protect_span == 3'h0)
      prot_hit = 1'b0;
    else if (c.protect_from_low_end)
      prot_hit = {1'b0, lo} < span;
    else
      prot_hit = {1'b0, hi} >= (ARRAY_TOP - span);
  endfunction

  // Pin synchronisers; every pin goes through the same two stages so the
  // lanes stay aligned with the clock edge that samples them.
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic       sclk_q;
  logic       sel_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 6'h01;
      pin_sync <= 6'h01;
      sclk_q   <= 1'b0;
      sel_q    <= 1'b0;
    end else begin
      pin_meta <= {lane_three, lane_two, lane_one, lane_zero,
                   serial_clock, select_n};
      pin_sync <= pin_meta;
      sclk_q   <= pin_sync[1];
      sel_q    <= !pin_sync[0];
    end
  end

  wire       sel_active  = !pin_sync[0];
  wire [3:0] lanes       = pin_sync[5:2];
  wire       frame_start = sel_active && !sel_q;
  wire       frame_end   = !sel_active && sel_q;
  wire       sclk_rise   = sel_active && pin_sync[1] && !sclk_q;

  // Serial frame capture.
  sfp_frame_type frame;
  sfp_frame_type next_frame;
  wire           quad_data = frame.opcode == OP_QUAD_PROG;
  wire           in_header = frame.hdr < HEADER_CLOCKS;

  always_comb begin
    next_frame = frame;
    if (frame_start) begin
      next_frame = '0;
    end else if (sclk_rise) begin
      if (frame.hdr < OPCODE_CLOCKS)
        next_frame.opcode = {frame.opcode[6:0], lanes[0]}; // RULE23
      else if (in_header)
        next_frame.addr = {frame.addr[22:0], lanes[0]};
      if (in_header)
        next_frame.hdr = frame.hdr + 6'h01;
      if (!in_header && quad_data) begin
        next_frame.data = {frame.data[3:0], lanes}; // RULE1 RULE3
        next_frame.dph  = frame.dph + 3'h4;
      end else if (!in_header) begin
        next_frame.data = {frame.data[6:0], lanes[0]};
        next_frame.dph  = frame.dph + 3'h1;
      end
      if (!in_header && next_frame.dph == 3'h0 && frame.bytes != PAGE_BYTES)
        next_frame.bytes = frame.bytes + 9'h001; // RULE2
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      frame <= '0;
    else
      frame <= next_frame;
  end

  // Sequencer state and the context of a suspended operation.
  sfp_state_type state;
  sfp_state_type next_state;
  sfp_kind_type  kind;
  sfp_kind_type  next_kind;
  sfp_kind_type  saved_kind;
  sfp_ctrl_type  ctrl;
  logic [23:0]   op_addr;
  logic [23:0]   next_addr;
  logic [23:0]   saved_addr;
  logic [31:0]   timer;
  logic [31:0]   next_timer;
  logic [31:0]   saved_rem;

  wire          idle      = state == ST_IDLE;
  wire [7:0]    op        = frame.opcode;
  wire          new_kind_is_erase = kind_of(op) inside
                                    {KIND_SECTOR, KIND_HALF, KIND_BLOCK};
  sfp_kind_type new_kind;
  assign new_kind = kind_of(op);

  // Select must rise exactly on a byte boundary with the expected length.
  wire no_addr_ok = frame.hdr == OPCODE_CLOCKS; // RULE7
  wire addr_ok    = frame.hdr == HEADER_CLOCKS && frame.bytes == 9'h000
                    && frame.dph == 3'h0; // RULE7
  wire prog_ok    = frame.hdr == HEADER_CLOCKS && frame.bytes != 9'h000
                    && frame.dph == 3'h0; // RULE3 RULE1

  wire [23:0] tgt_mask = region_mask(new_kind);
  wire [23:0] tgt_lo   = frame.addr & tgt_mask;
  wire [23:0] tgt_hi   = tgt_lo | ~tgt_mask;
  wire        tgt_prot = prot_hit(ctrl, tgt_lo, tgt_hi); // RULE10
  wire [23:0] sv_mask  = region_mask(saved_kind);
  wire        same_tgt = suspended_flag
                         && (frame.addr & sv_mask) == (saved_addr & sv_mask);

  wire erase_go = frame_end && idle && addr_ok && new_kind_is_erase
                  && write_arm_latch && !suspended_flag
                  && !tgt_prot; // RULE4 RULE5 RULE13 RULE14
  wire chip_go  = frame_end && idle && no_addr_ok && new_kind == KIND_CHIP
                  && write_arm_latch && !suspended_flag
                  && ctrl.protect_span == 3'h0; // RULE6 RULE10 RULE13
  wire prog_go  = frame_end && idle && prog_ok && new_kind == KIND_PROGRAM
                  && write_arm_latch
                  && (op != OP_QUAD_PROG || ctrl.four_lane_allow) // RULE1
                  && !(suspended_flag && saved_kind == KIND_PROGRAM) // RULE14
                  && !same_tgt // RULE16 RULE15
                  && !tgt_prot; // RULE10 RULE3
  wire start_go = erase_go || chip_go || prog_go;
  wire susp_go  = frame_end && no_addr_ok && op == OP_SUSPEND
                  && !suspended_flag && state == ST_RUN
                  && kind != KIND_CHIP; // RULE11 RULE12
  wire resume_go = frame_end && idle && no_addr_ok && op == OP_RESUME
                   && suspended_flag; // RULE20
  wire arm_go    = frame_end && idle && no_addr_ok && op == OP_WRITE_ARM;
  wire disarm_go = frame_end && idle && no_addr_ok && op == OP_WRITE_DISARM;
  wire done      = state == ST_RUN && timer == 32'h0 && !susp_go;
  wire accepted  = start_go || susp_go || resume_go || arm_go || disarm_go;

  always_comb begin
    next_state = state;
    next_kind  = kind;
    next_addr  = op_addr;
    next_timer = timer;
    case (state)
      ST_IDLE: begin
        if (start_go) begin
          next_state = ST_RUN; // RULE8
          next_kind  = new_kind;
          next_addr  = frame.addr;
          next_timer = duration(new_kind) - 32'h1;
        end else if (resume_go) begin
          next_state = ST_RUN; // RULE21
          next_kind  = saved_kind;
          next_addr  = saved_addr;
          next_timer = saved_rem;
        end
      end
      ST_RUN: begin
        if (susp_go) begin
          next_state = ST_HALT; // RULE17
          next_timer = 32'(SUSPEND_LATENCY_CYC) - 32'h1;
        end else if (timer == 32'h0) begin
          next_state = ST_IDLE; // RULE9
          next_kind  = KIND_NONE;
        end else begin
          next_timer = timer - 32'h1;
        end
      end
      ST_HALT: begin
        if (timer == 32'h0)
          next_state = ST_IDLE; // RULE17
        else
          next_timer = timer - 32'h1;
      end
      default: begin
        next_state = ST_IDLE;
        next_kind  = KIND_NONE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= ST_IDLE;
      kind    <= KIND_NONE;
      op_addr <= 24'h000000;
      timer   <= 32'h0;
    end else begin
      state   <= next_state;
      kind    <= next_kind;
      op_addr <= next_addr;
      timer   <= next_timer;
    end
  end

  // Reset stands for power loss: the suspended context is dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      suspended_flag <= 1'b0; // RULE19
      saved_kind     <= KIND_NONE;
      saved_addr     <= 24'h000000;
      saved_rem      <= 32'h0;
    end else if (susp_go) begin
      suspended_flag <= 1'b1; // RULE17
      saved_kind     <= kind;
      saved_addr     <= op_addr;
      saved_rem      <= timer;
    end else if (resume_go) begin
      suspended_flag <= 1'b0; // RULE21
    end
  end

  // Arming ahead of the clear so a set in the same cycle would win.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      write_arm_latch <= 1'b0;
    else if (arm_go)
      write_arm_latch <= 1'b1; // RULE22
    else if (done || disarm_go)
      write_arm_latch <= 1'b0; // RULE9 RULE3
  end

  assign busy = state != ST_IDLE; // RULE8

  // Record of the last command frame; refused frames only log here.
  logic [23:0] last_addr;
  logic [8:0]  last_bytes;
  logic [7:0]  last_data;
  logic [7:0]  last_opcode;
  logic        last_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_addr   <= 24'h000000;
      last_bytes  <= 9'h000;
      last_data   <= 8'h00;
      last_opcode <= 8'h00;
      last_ok     <= 1'b0;
    end else if (frame_end) begin
      last_opcode <= op;
      last_ok     <= accepted; // RULE24
      if (start_go)
        last_addr <= frame.addr;
      if (prog_go) begin
        last_bytes <= frame.bytes; // RULE2
        last_data  <= frame.data;
      end
    end
  end

  // APB slave: zero wait states, read data latched in the setup phase.
  wire        apb_setup = psel && !penable;
  wire        apb_write = psel && penable && pwrite;
  wire        hit_ctrl  = paddr == ADDR_CTRL;
  wire        hit_any   = hit_ctrl || paddr == ADDR_STATUS
                          || paddr == ADDR_LAST_ADDR
                          || paddr == ADDR_LAST_INFO;
  logic [31:0] rd_value;

  always_comb begin
    rd_value = 32'h0;
    case (paddr)
      ADDR_CTRL:      rd_value[5:0] = ctrl;
      ADDR_STATUS: begin
        rd_value[STATUS_BUSY_BIT] = busy; // RULE8
        rd_value[STATUS_ARM_BIT]  = write_arm_latch;
        rd_value[STATUS_SUSP_BIT] = suspended_flag;
      end
      ADDR_LAST_ADDR: rd_value[23:0] = last_addr;
      ADDR_LAST_INFO: begin
        rd_value[INFO_BYTES_LSB +: 9]  = last_bytes;
        rd_value[INFO_BYTES_LSB + 15]  = last_ok;
        rd_value[INFO_DATA_LSB +: 8]   = last_data;
        rd_value[INFO_OPCODE_LSB +: 8] = last_opcode;
      end
      default:        rd_value = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      ctrl   <= CTRL_RESET;
    end else begin
      if (apb_setup)
        prdata <= rd_value;
      if (apb_write && hit_ctrl)
        ctrl <= pwdata[5:0];
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  busy_start_a: assert property (start_go |=> busy) // RULE8
    else $error("busy did not rise after an accepted command");
  arm_clear_a: assert property (done |=> !write_arm_latch && !busy) // RULE9
    else $error("cycle end left arm latch or busy set");
  susp_flag_a: assert property (susp_go |=> suspended_flag && busy) // RULE17
    else $error("suspend did not set the flag at once");
  // The latency is far longer than a delay range may span, so a counter
  // tracks how long busy has stood since the accepted suspend.
  logic [11:0] halt_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      halt_cnt <= 12'h000;
    else if (susp_go)
      halt_cnt <= 12'h001;
    else if (halt_cnt != 12'h000 && busy)
      halt_cnt <= halt_cnt + 12'h001;
    else
      halt_cnt <= 12'h000;
  end

  susp_latency_a: assert property (
    32'(halt_cnt) <= susp_bound) // RULE17
    else $error("busy outlived the suspend latency");
  resume_busy_a: assert property (
    resume_go |=> !suspended_flag ##0 (##[0:resume_bound] busy)) // RULE21
    else $error("resume did not clear flag and raise busy");
  chip_nosusp_a: assert property (
    (frame_end && op == OP_SUSPEND && kind == KIND_CHIP)
    |=> !suspended_flag) // RULE12
    else $error("chip erase was suspended");
  erase_gate_a: assert property (
    (erase_go || chip_go) |-> write_arm_latch && !suspended_flag) // RULE13
    else $error("erase started without arm or while suspended");
  quad_gate_a: assert property (
    (prog_go && op == OP_QUAD_PROG) |-> ctrl.four_lane_allow) // RULE1
    else $error("quad program started without four-lane allow");
  chip_prot_a: assert property (chip_go |-> ctrl.protect_span == 3'h0) // RULE10
    else $error("chip erase started with protection set");
  byte_cap_a: assert property (frame.bytes <= PAGE_BYTES) // RULE2
    else $error("program byte count passed one page");
  resume_ign_a: assert property (
    (frame_end && op == OP_RESUME && busy)
    |=> $stable(suspended_flag)) // RULE20
    else $error("resume acted while busy");

  erase_done_c: cover property (done && kind == KIND_SECTOR);
  susp_resume_c: cover property (resume_go && saved_kind == KIND_SECTOR);
  quad_prog_c: cover property (prog_go && op == OP_QUAD_PROG);
  nested_prog_c: cover property (prog_go && suspended_flag);

endmodule

// ===== shared/sfp_pkg.sv
// Constants, opcodes, register map and carrier types of the flash sequencer.
package sfp_pkg;

  // Command opcodes.
  localparam logic [7:0] OP_WRITE_ARM     = 8'h06;
  localparam logic [7:0] OP_WRITE_DISARM  = 8'h04;
  localparam logic [7:0] OP_PAGE_PROG     = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG     = 8'h32;
  localparam logic [7:0] OP_SECTOR_ERASE  = 8'h20;
  localparam logic [7:0] OP_HALF_ERASE    = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE   = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A  = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_B  = 8'h60;
  localparam logic [7:0] OP_SUSPEND       = 8'h75;
  localparam logic [7:0] OP_RESUME        = 8'h7a;

  // Serial framing: clocks in the opcode and in opcode plus address.
  localparam logic [5:0] OPCODE_CLOCKS    = 6'h08;
  localparam logic [5:0] HEADER_CLOCKS    = 6'h20;
  localparam logic [8:0] PAGE_BYTES       = 9'h100;

  // Target region masks and protection geometry.
  localparam logic [23:0] PAGE_MASK       = 24'hffff00;
  localparam logic [23:0] SECTOR_MASK     = 24'hfff000;
  localparam logic [23:0] HALF_MASK       = 24'hff8000;
  localparam logic [23:0] BLOCK_MASK      = 24'hff0000;
  localparam logic [24:0] PROT_SMALL_UNIT = 25'h0001000;
  localparam logic [24:0] PROT_LARGE_UNIT = 25'h0010000;
  localparam logic [24:0] ARRAY_TOP       = 25'h1000000;

  // Timing.
  localparam int CLK_PERIOD_NS            = 10;
  localparam int PROGRAM_DURATION_US      = 400;
  localparam int SMALL_ERASE_DURATION_US  = 50000;
  localparam int HALF_ERASE_DURATION_US   = 120000;
  localparam int LARGE_ERASE_DURATION_US  = 150000;
  localparam int WHOLE_ERASE_DURATION_US  = 1000000;
  localparam int SUSPEND_LATENCY_MAX_US   = 20;
  localparam int RESUME_BUSY_MAX_NS       = 200;
  localparam int PROGRAM_CYC     = PROGRAM_DURATION_US * 1000 / CLK_PERIOD_NS;
  localparam int SMALL_ERASE_CYC =
    SMALL_ERASE_DURATION_US * 1000 / CLK_PERIOD_NS;
  localparam int HALF_ERASE_CYC  = HALF_ERASE_DURATION_US * 1000 / CLK_PERIOD_NS;
  localparam int LARGE_ERASE_CYC =
    LARGE_ERASE_DURATION_US * 1000 / CLK_PERIOD_NS;
  localparam int WHOLE_ERASE_CYC =
    WHOLE_ERASE_DURATION_US * 1000 / CLK_PERIOD_NS;
  localparam int SUSPEND_LATENCY_CYC =
    SUSPEND_LATENCY_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int RESUME_BUSY_CYC = RESUME_BUSY_MAX_NS / CLK_PERIOD_NS;

  // APB register map and fields.
  localparam logic [7:0] ADDR_CTRL        = 8'h00;
  localparam logic [7:0] ADDR_STATUS      = 8'h04;
  localparam logic [7:0] ADDR_LAST_ADDR   = 8'h08;
  localparam logic [7:0] ADDR_LAST_INFO   = 8'h0c;
  localparam logic [5:0] CTRL_RESET       = 6'h00;
  localparam int STATUS_BUSY_BIT          = 0;
  localparam int STATUS_ARM_BIT           = 1;
  localparam int STATUS_SUSP_BIT          = 2;
  localparam int INFO_BYTES_LSB           = 0;
  localparam int INFO_DATA_LSB            = 16;
  localparam int INFO_OPCODE_LSB          = 24;

  typedef struct packed {
    logic       protect_granule_select;
    logic       protect_from_low_end;
    logic [2:0] protect_span;
    logic       four_lane_allow;
  } sfp_ctrl_type;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [8:0]  bytes;
    logic [5:0]  hdr;
    logic [2:0]  dph;
    logic [7:0]  data;
  } sfp_frame_type;

  typedef enum logic [2:0] {
    KIND_NONE, KIND_PROGRAM, KIND_SECTOR, KIND_HALF, KIND_BLOCK, KIND_CHIP
  } sfp_kind_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_HALT = 3'b100
  } sfp_state_type;

endpackage

// ===== verif/sfp_host_model.sv
// Host serial flash controller model that drives command frames.
`timescale 1ns/1ps

module sfp_host_model (
  // Serial pins toward the device.
  output logic select_n,
  output logic serial_clock,
  output logic lane_zero,
  output logic lane_one,
  output logic lane_two,
  output logic lane_three
);
  initial begin
    select_n     = 1'b1;
    serial_clock = 1'b0;
    {lane_three, lane_two, lane_one, lane_zero} = 4'h5;
  end

  // The clock stands still between frames; released lanes show the
  // inverse of their last value so stale bits are never mistaken for data.
  task automatic send(input logic [7:0] op, input logic [23:0] a,
                      input int aclk, input int dclk, input logic quad,
                      input logic [31:0] d);
    logic [31:0] sh;
    sh = {op, a};
    select_n = 1'b0;
    #80;
    for (int i = 0; i < 8 + aclk + dclk; i++) begin
      if (i < 8 + aclk)
        lane_zero = sh[31 - i];
      else if (quad)
        {lane_three, lane_two, lane_one, lane_zero} = d[(4 * i) % 32 +: 4];
      else
        lane_zero = d[i % 32];
      #80 serial_clock = 1'b1;
      #80 serial_clock = 1'b0;
    end
    #80 select_n = 1'b1;
    {lane_three, lane_two, lane_one, lane_zero} =
      ~{lane_three, lane_two, lane_one, lane_zero};
    #1000;
  endtask
endmodule

// ===== verif/sfp_sequencer_tb_top.sv
// Self-checking bench of the flash sequencer against a status model.
`timescale 1ns/1ps

`define CHK(nm, ex, got) \
  begin \
    cmp_count++; \
    if ((got) !== (ex)) begin \
      fails++; \
      $display("ERROR %s expected %h seen %h", nm, ex, got); \
    end \
  end

module sfp_sequencer_tb_top import sfp_pkg::*;;
  localparam int LONG_CYC  = 3000;
  localparam int SHORT_CYC = 200;
  localparam int LIMIT     = 80000;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        sel_n, sclk, l0, l1, l2, l3, busy, arm, susp, err;
  logic        ex_b, ex_a, ex_s;
  logic [23:0] addr;
  logic [7:0]  ops [5];
  int          fails, cmp_count;
  int          cycles = 0;
  integer      seed;

  sfp_sequencer #(
    .PROGRAM_CYCLES(400), .SMALL_ERASE_CYCLES(LONG_CYC),
    .HALF_ERASE_CYCLES(SHORT_CYC), .LARGE_ERASE_CYCLES(SHORT_CYC),
    .WHOLE_ERASE_CYCLES(LONG_CYC)
  ) i_sfp_sequencer (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .select_n(sel_n), .serial_clock(sclk), .lane_zero(l0),
    .lane_one(l1), .lane_two(l2), .lane_three(l3), .busy(busy),
    .write_arm_latch(arm), .suspended_flag(susp)
  );

  sfp_host_model i_sfp_host_model (
    .select_n(sel_n), .serial_clock(sclk), .lane_zero(l0),
    .lane_one(l1), .lane_two(l2), .lane_three(l3)
  );

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails = fails + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check_status();
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("status", {ex_s, ex_a, ex_b}, rd[2:0])
  endtask

  task automatic frame(input logic [7:0] op, input logic [23:0] a,
                       input int aclk, input int dclk, input logic quad);
    i_sfp_host_model.send(op, a, aclk, dclk, quad, $random(seed));
  endtask

  // Bounded wait for the end of a self-timed cycle or suspend latency.
  task automatic wait_idle(input int lim);
    for (int n = 0; n < lim && busy !== 1'b0; n++)
      @(posedge pclk);
  endtask

  initial begin
    seed = 32'h81f6;
    ops = '{OP_SECTOR_ERASE, OP_HALF_ERASE, OP_BLOCK_ERASE,
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {ex_s, ex_a, ex_b} = 3'h0;
    presetn = 1'b0;
    fails = 0;
    cmp_count = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    check_status();
    apb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 1'b1, err)
    apb(1'b1, ADDR_CTRL, 32'h0);
    addr = 24'($random(seed)) & SECTOR_MASK & 24'h7fffff;
    frame(OP_SECTOR_ERASE, addr, 24, 0, 1'b0);
    check_status();
    frame(OP_WRITE_ARM, 24'h0, 0, 0, 1'b0);
    ex_a = 1'b1;
    check_status();
    frame(OP_SECTOR_ERASE, addr, 23, 0, 1'b0);
    check_status();
    frame(OP_QUAD_PROG, addr, 24, 2, 1'b1);
    check_status();
    apb(1'b1, ADDR_CTRL, 32'h1);
    frame(OP_QUAD_PROG, addr, 24, 4, 1'b1);
    ex_b = 1'b1;
    check_status();
    wait_idle(5000);
    {ex_a, ex_b} = 2'h0;
    check_status();
    apb(1'b0, ADDR_LAST_INFO, 32'h0);
    `CHK("bytes", 9'h002, rd[8:0])
    // Lowest 64K (sixteen 4K granules) protected: sector 0 and the whole chip refused.
    apb(1'b1, ADDR_CTRL, 32'h3b);
    frame(OP_WRITE_ARM, 24'h0, 0, 0, 1'b0);
    ex_a = 1'b1;
    frame(OP_SECTOR_ERASE, 24'h000000, 24, 0, 1'b0);
    check_status();
    frame(OP_CHIP_ERASE_A, 24'h0, 0, 0, 1'b0);
    check_status();
    apb(1'b1, ADDR_CTRL, 32'h1);
    foreach (ops[i]) begin
      frame(OP_WRITE_ARM, 24'h0, 0, 0, 1'b0);
      frame(ops[i], addr, (i < 3) ? 24 : 0, 0, 1'b0);
      {ex_a, ex_b} = 2'h3;
      check_status();
      if (i > 2) begin
        frame(OP_SUSPEND, 24'h0, 0, 0, 1'b0);
        check_status();
      end
      wait_idle(5000);
      {ex_a, ex_b} = 2'h0;
      check_status();
    end
    frame(OP_WRITE_ARM, 24'h0, 0, 0, 1'b0);
    frame(OP_SECTOR_ERASE, addr, 24, 0, 1'b0);
    frame(OP_SUSPEND, 24'h0, 0, 0, 1'b0);
    {ex_s, ex_a, ex_b} = 3'h7;
    check_status();
    wait_idle(2100);
    ex_b = 1'b0;
    check_status();
    frame(OP_BLOCK_ERASE, addr ^ 24'h800000, 24, 0, 1'b0);
    check_status();
    frame(OP_SUSPEND, 24'h0, 0, 0, 1'b0);
    check_status();
    frame(OP_QUAD_PROG, addr, 24, 2, 1'b1);
    check_status();
    frame(OP_RESUME, 24'h0, 0, 0, 1'b0);
    {ex_s, ex_b} = 2'h1;
    check_status();
    frame(OP_RESUME, 24'h0, 0, 0, 1'b0);
    check_status();
    repeat (200) @(posedge pclk);
    frame(OP_SUSPEND, 24'h0, 0, 0, 1'b0);
    ex_s = 1'b1;
    check_status();
    @(posedge pclk) presetn <= 1'b0;
    @(posedge pclk) presetn <= 1'b1;
    {ex_s, ex_a, ex_b} = 3'h0;
    repeat (4) @(posedge pclk);
    check_status();
    give_verdict();
  end
endmodule
